// *** dv/serial_eeprom_twowire_slave_tb_top.sv ***
// self-checking bench for the two-wire eeprom slave
module serial_eeprom_twowire_slave_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import eeprom_pkg::*;

   localparam int unsigned WC = 2000;
   localparam logic [3:0]  DT = DEVICE_TYPE_DEF;
   localparam logic [7:0]  SW = {DT, 3'h5, 1'b0};

   typedef struct packed {
      logic [2:0] sel;
      logic [7:0] slave;
      logic [7:0] wa;
      logic [7:0] d;
      logic       ack;
   } row_t;

   logic       ref_clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic [2:0] sel     = 3'h5;
   logic       scl;
   logic       sda_pull;
   logic       sda_out;
   logic       sda_oe;
   logic       busy;
   logic       standby;
   wire logic  sda_in;
   logic       a;
   logic [7:0] wq[$];
   logic [7:0] eq[$];
   int         num_errors = 0;
   int         checked    = 0;
   int         cycles     = 0;

   row_t rows [8] = '{
      '{3'h5, {DT, 3'h5, 1'b0}, 8'h3C, 8'hA5, 1'b1},
      '{3'h0, {DT, 3'h0, 1'b0}, 8'h10, 8'h01, 1'b1},
      '{3'h7, {DT, 3'h7, 1'b0}, 8'h11, 8'h7E, 1'b1},
      '{3'h5, {DT, 3'h4, 1'b0}, 8'h3C, 8'hFF, 1'b0},
      '{3'h5, {DT, 3'h7, 1'b0}, 8'h3C, 8'hFF, 1'b0},
      '{3'h5, {DT, 3'h1, 1'b0}, 8'h3C, 8'hFF, 1'b0},
      '{3'h5, {DT ^ 4'h8, 3'h5, 1'b0}, 8'h3C, 8'hFF, 1'b0},
      '{3'h5, {DT ^ 4'h1, 3'h5, 1'b0}, 8'h3C, 8'hFF, 1'b0}
   };

   // wire is pulled up unless a side pulls it low
   assign sda_in = ~(sda_pull | sda_oe);

   always #2 ref_clk = ~ref_clk;

   eeprom_slave #(
      .WRITE_CNT (WC),
      .DEV_TYPE  (DT)
   ) u_dut (
      .REF_CLK         (ref_clk),
      .SYS_RST         (sys_rst),
      .SCL             (scl),
      .SDA_IN          (sda_in),
      .SDA_OUT         (sda_out),
      .SDA_OE          (sda_oe),
      .SELECT_BIT_LOW  (sel[0]),
      .SELECT_BIT_MID  (sel[1]),
      .SELECT_BIT_HIGH (sel[2]),
      .WRITE_BUSY      (busy),
      .STANDBY         (standby)
   );

   twowire_master_model u_m (
      .ref_clk  (ref_clk),
      .sda_line (sda_in),
      .scl      (scl),
      .sda_pull (sda_pull)
   );

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // slave byte, word address, bytes of wq, stop, then busy polling
   task automatic write_seq(input logic [7:0] slave, input logic [7:0] wa,
                            input logic exp, input logic done);
      int n;
      u_m.start();
      u_m.write_byte(slave, a);
      check(a, exp);
      if (exp)
      begin
         u_m.write_byte(wa, a);
         check(a, 1'b1);
         foreach (wq[i])
         begin
            u_m.write_byte(wq[i], a);
            check(a, 1'b1);
         end
      end
      u_m.stop();
      check(busy, exp);
      check(standby, !exp);
      if (exp)
      begin
         u_m.start();
         u_m.write_byte(slave, a);
         check(a, 1'b0);
         u_m.stop();
         if (done)
         begin
            n = 0;
            while (busy === 1'b1 && n <= WC)
            begin
               @(posedge ref_clk);
               n++;
            end
            check(n <= WC, 1'b1);
            repeat (2) @(posedge ref_clk);
            check(standby, 1'b1);
         end
      end
   endtask

   // optional dummy write, then read of every byte in eq
   task automatic read_seq(input logic [7:0] slave, input logic [7:0] wa,
                           input logic rnd);
      logic [7:0] d;
      if (rnd)
      begin
         u_m.start();
         u_m.write_byte(slave, a);
         check(a, 1'b1);
         u_m.write_byte(wa, a);
         check(a, 1'b1);
      end
      u_m.start();
      u_m.write_byte(slave | 8'h01, a);
      check(a, 1'b1);
      foreach (eq[i])
      begin
         u_m.read_byte(i < eq.size() - 1, d);
         check(d, eq[i]);
      end
      u_m.stop();
   endtask

   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 80000)
      begin
         num_errors = num_errors + 1;
         summarize();
      end
   end

   initial
   begin
      repeat (16) @(posedge ref_clk);
      check(sda_oe, 1'b0);
      check(busy, 1'b0);
      check(standby, 1'b1);
      check(sda_out, 1'b0);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      u_m.raw_bits({SW, 1'b1}, a);
      check(a, 1'b1);
      check(standby, 1'b1);
      foreach (rows[i])
      begin
         sel <= rows[i].sel;
         repeat (4) @(posedge ref_clk);
         wq.delete();
         wq.push_back(rows[i].d);
         write_seq(rows[i].slave, rows[i].wa, rows[i].ack, 1'b1);
      end
      sel <= 3'h5;
      repeat (4) @(posedge ref_clk);
      eq = {8'hA5};
      read_seq(SW, 8'h3C, 1'b1);
      eq = {8'h01, 8'h7E};
      read_seq(SW, 8'h10, 1'b1);
      // page write crossing the page end wraps to its start
      wq = {8'h11, 8'h22, 8'h33, 8'h44};
      write_seq(SW, 8'h2E, 1'b1, 1'b1);
      eq = {8'h11, 8'h22};
      read_seq(SW, 8'h2E, 1'b1);
      eq = {8'h33, 8'h44};
      read_seq(SW, 8'h20, 1'b1);
      // pointer wraps from the top of the array
      wq = {8'h5A};
      write_seq(SW, 8'hFF, 1'b1, 1'b1);
      wq = {8'hC3};
      write_seq(SW, 8'h00, 1'b1, 1'b1);
      eq = {8'h5A};
      read_seq(SW, 8'hFF, 1'b1);
      eq = {8'hC3};
      read_seq(SW, 8'h00, 1'b0);
      // start in mid data byte abandons the write
      u_m.start();
      u_m.write_byte(SW, a);
      u_m.write_byte(8'h40, a);
      repeat (3) u_m.xfer_bit(1'b0, a);
      u_m.start();
      u_m.stop();
      check(busy, 1'b0);
      check(standby, 1'b1);
      // reset reasserted during a write cycle
      wq = {8'h99};
      write_seq(SW, 8'h50, 1'b1, 1'b0);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      check(busy, 1'b0);
      check(standby, 1'b1);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      eq = {8'hC3};
      read_seq(SW, 8'h00, 1'b0);
      summarize();
   end
endmodule

// *** dv/twowire_master_model.sv ***
// behavioural two-wire bus master driving the eeprom slave
module twowire_master_model
(
   input  wire logic ref_clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_pull
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus: clock stands high, data released
   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // one pulse per bit, data moves only while clock low
   task automatic xfer_bit(input logic b, output logic r);
      wait_cyc(4);
      sda_pull <= ~b;
      wait_cyc(12);
      scl <= 1'b1;
      wait_cyc(12);
      r = sda_line;
      wait_cyc(3);
      scl <= 1'b0;
   endtask

   // data falls while clock high, from an idle bus or as a repeated start
   task automatic start();
      wait_cyc(4);
      sda_pull <= 1'b0;
      wait_cyc(12);
      scl <= 1'b1;
      wait_cyc(12);
      sda_pull <= 1'b1;
      wait_cyc(12);
      scl <= 1'b0;
   endtask

   // data rises while clock high, closing every operation
   task automatic stop();
      wait_cyc(4);
      sda_pull <= 1'b1;
      wait_cyc(12);
      scl <= 1'b1;
      wait_cyc(12);
      sda_pull <= 1'b0;
      wait_cyc(12);
   endtask

   // msb first, ninth clock released for the ack
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         xfer_bit(d[i], r);
      xfer_bit(1'b1, r);
      ack = ~r;
   endtask

   // master pulls low to continue, releases on the last byte
   task automatic read_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         xfer_bit(1'b1, r);
         d[i] = r;
      end
      xfer_bit(~more, r);
   endtask

   // nine clocks with no start, as used for bus recovery
   task automatic raw_bits(input logic [8:0] v, output logic r);
      scl <= 1'b0;
      for (int i = 8; i >= 0; i--)
         xfer_bit(v[i], r);
      wait_cyc(4);
      sda_pull <= 1'b0;
      wait_cyc(12);
      scl <= 1'b1;
      wait_cyc(4);
   endtask
endmodule

// *** logic/eeprom_pkg.sv ***
// constants and types shared by the serial eeprom slave
package eeprom_pkg;
   // slave address byte layout
   localparam int unsigned TYPE_MSB     = 7;
   localparam int unsigned TYPE_LSB     = 4;
   localparam int unsigned SEL_MSB      = 3;
   localparam int unsigned SEL_LSB      = 1;
   localparam int unsigned RW_BIT       = 0;
   // arbitrary neutral device-type code
   localparam logic [3:0]  DEVICE_TYPE_DEF = 4'h5;

   // framing
   localparam logic [3:0]  BYTE_BITS    = 4'h8;
   localparam logic [3:0]  CNT_RESET    = 4'h0;

   // array shape
   localparam int unsigned ADDR_W       = 8;
   localparam int unsigned MEM_BYTES    = 256;
   localparam int unsigned PAGE_BYTES   = 16;
   localparam int unsigned PAGE_W       = 4;
   localparam logic [7:0]  PTR_RESET    = 8'h00;

   // self-timed write cycle
   localparam int unsigned WRITE_TIME_US = 5000;
   localparam int unsigned REF_CLK_MHZ   = 250;
   localparam int unsigned WRITE_CYCLES  = WRITE_TIME_US * REF_CLK_MHZ;
   localparam int unsigned WCNT_W        = 21;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SLAVE,
      ST_WORD,
      ST_WDATA,
      ST_RDATA
   } state_t;
endpackage

// *** logic/eeprom_slave.sv ***
// two-wire slave front end of a 256x8 serial eeprom with 16-byte pages

// Functional notes
// - SDA falling while SCL high is a Start; every command begins with one.
// - SDA rising while SCL high is a Stop.
// - SDA changes only while SCL low; changes during SCL high are Start/Stop.
// - all bus activity is ignored until a Start is seen.
// - one SCL pulse per bit; data valid after Start, transfer ends at Stop.
// - the receiver of a byte pulls SDA low on the following clock.
// - first byte is the slave address; upper four bits match device type.
// - next three bits match the unit's select pins; eight units per bus.
// - address bit zero selects direction: 1 read, 0 write.
// - on match, SDA is held low in the ninth clock, then read or write.
// - byte write: slave byte, word address into pointer, data; all acked.
// - Stop after a write starts the timed program cycle; no answers meanwhile.
// - the internal write cycle lasts at most 5 ms.
// - array is 256 bytes of 8 bits, grouped in 16-byte pages.
// - a new Start resets the serial interface, also mid-transfer.
// - nothing is accepted in reset; release gives standby; reassert returns.
// - standby after Stop with no write pending, and after the write cycle.
// - writes step only the low four pointer bits; up to 16 bytes per cycle.
// - slave address is not acknowledged while the write cycle runs.
// - pointer holds last address plus one; reads step and wrap at the top.
module eeprom_slave
   import eeprom_pkg::*;
#(
   parameter int unsigned WRITE_CNT = eeprom_pkg::WRITE_CYCLES,
   parameter logic [3:0]  DEV_TYPE  = eeprom_pkg::DEVICE_TYPE_DEF
)
(
   input  wire logic REF_CLK,
   input  wire logic SYS_RST,
   input  wire logic SCL,
   input  wire logic SDA_IN,
   output logic      SDA_OUT,
   output logic      SDA_OE,
   input  wire logic SELECT_BIT_LOW,
   input  wire logic SELECT_BIT_MID,
   input  wire logic SELECT_BIT_HIGH,
   output logic      WRITE_BUSY,
   output logic      STANDBY
);
   import eeprom_pkg::*;

   logic [1:0]            scl_sync_reg;
   logic [1:0]            sda_sync_reg;
   logic [2:0]            sel_s1_reg;
   logic [2:0]            sel_reg;
   logic                  scl_d_reg;
   logic                  sda_d_reg;
   logic                  scl_rise;
   logic                  scl_fall;
   logic                  start_det;
   logic                  stop_det;
   logic                  scl_now;
   logic                  sda_now;
   state_t                state_reg;
   logic [3:0]            cnt_reg;
   logic                  ack_phase_reg;
   logic                  ack_reg;
   logic                  mack_reg;
   logic [7:0]            shift_reg;
   logic [7:0]            tx_reg;
   logic [ADDR_W-1:0]     ptr_reg;
   logic [PAGE_W-1:0]     page_reg;
   logic [PAGE_BYTES-1:0] mask_reg;
   logic                  wrote_reg;
   logic [7:0]            pbuf     [PAGE_BYTES];
   logic [7:0]            mem      [MEM_BYTES];
   logic                  busy_reg;
   logic [WCNT_W-1:0]     wcnt_reg;
   logic                  sda_oe_reg;
   logic                  standby_reg;
   logic                  byte_done;
   logic                  ack_end;
   logic                  take_byte;
   // decides whether a completed byte earns an acknowledge
   function automatic logic accept_byte(
      input state_t     st,
      input logic [7:0] b,
      input logic       busy,
      input logic [2:0] sel,
      input logic [3:0] dtype
   );
      logic ok;
      ok = 1'b1;
      if (st == ST_SLAVE)
         ok = !busy && (b[TYPE_MSB:TYPE_LSB] == dtype)
              && (b[SEL_MSB:SEL_LSB] == sel);
      return ok;
   endfunction

   // two-flop synchronisers for pins
   always_ff @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         sel_s1_reg   <= 3'h0;
         sel_reg      <= 3'h0;
         scl_d_reg    <= 1'b1;
         sda_d_reg    <= 1'b1;
      end
      else
      begin
         scl_sync_reg <= {scl_sync_reg[0], SCL};
         sda_sync_reg <= {sda_sync_reg[0], SDA_IN};
         sel_s1_reg   <= {SELECT_BIT_HIGH, SELECT_BIT_MID, SELECT_BIT_LOW};
         sel_reg      <= sel_s1_reg;
         scl_d_reg    <= scl_sync_reg[1];
         sda_d_reg    <= sda_sync_reg[1];
      end
   end

   assign scl_now   = scl_sync_reg[1];
   assign sda_now   = sda_sync_reg[1];
   assign scl_rise  = scl_now && !scl_d_reg;
   assign scl_fall  = !scl_now && scl_d_reg;
   // sda moving while scl stays high is a condition, never data
   assign start_det = scl_now && scl_d_reg && sda_d_reg && !sda_now;
   assign stop_det  = scl_now && scl_d_reg && !sda_d_reg && sda_now;

   assign byte_done = scl_fall && (cnt_reg == BYTE_BITS) && !ack_phase_reg;
   assign ack_end   = scl_fall && ack_phase_reg;
   assign take_byte = byte_done && accept_byte(state_reg, shift_reg,
                                               busy_reg, sel_reg, DEV_TYPE);

   // bit framing, addressing and pointer
   always_ff @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         state_reg     <= ST_IDLE;
         cnt_reg       <= CNT_RESET;
         ack_phase_reg <= 1'b0;
         ack_reg       <= 1'b0;
         mack_reg      <= 1'b0;
         shift_reg     <= 8'h00;
         tx_reg        <= 8'h00;
         ptr_reg       <= PTR_RESET;
         page_reg      <= '0;
         mask_reg      <= '0;
         wrote_reg     <= 1'b0;
      end
      else if (start_det)
      begin
         // start aborts the transfer in flight but keeps buffered write data and wrote_reg for the next stop
         state_reg     <= ST_SLAVE;
         cnt_reg       <= CNT_RESET;
         ack_phase_reg <= 1'b0;
         ack_reg       <= 1'b0;
      end
      else if (stop_det)
      begin
         state_reg     <= ST_IDLE;
         cnt_reg       <= CNT_RESET;
         ack_phase_reg <= 1'b0;
         ack_reg       <= 1'b0;
         wrote_reg     <= 1'b0;
         mask_reg      <= '0;
      end
      else
      begin
         case (state_reg)
            ST_IDLE: cnt_reg <= CNT_RESET;
            ST_SLAVE, ST_WORD, ST_WDATA:
            begin
               if (scl_rise && (cnt_reg < BYTE_BITS))
               begin
                  shift_reg <= {shift_reg[6:0], sda_now};
                  cnt_reg   <= cnt_reg + 4'h1;
               end
               else if (byte_done)
               begin
                  if (take_byte)
                  begin
                     ack_reg       <= 1'b1;
                     ack_phase_reg <= 1'b1;
                     if (state_reg == ST_WORD)
                        ptr_reg <= shift_reg;
                     else if (state_reg == ST_WDATA)
                     begin
                        pbuf[ptr_reg[PAGE_W-1:0]]     <= shift_reg;
                        mask_reg[ptr_reg[PAGE_W-1:0]] <= 1'b1;
                        page_reg  <= ptr_reg[ADDR_W-1:PAGE_W];
                        ptr_reg[PAGE_W-1:0] <=
                           ptr_reg[PAGE_W-1:0] + 4'h1;
                        wrote_reg <= 1'b1;
                     end
                  end
                  else
                     state_reg <= ST_IDLE;
               end
               else if (ack_end)
               begin
                  ack_reg       <= 1'b0;
                  ack_phase_reg <= 1'b0;
                  cnt_reg       <= CNT_RESET;
                  if (state_reg == ST_SLAVE)
                  begin
                     if (shift_reg[RW_BIT])
                     begin
                        state_reg <= ST_RDATA;
                        tx_reg    <= mem[ptr_reg];
                        ptr_reg   <= ptr_reg + 8'h01;
                     end
                     else
                        state_reg <= ST_WORD;
                  end
                  else
                     state_reg <= ST_WDATA;
               end
            end
            ST_RDATA:
            begin
               if (scl_fall && (cnt_reg < BYTE_BITS))
               begin
                  tx_reg  <= {tx_reg[6:0], 1'b0};
                  cnt_reg <= cnt_reg + 4'h1;
               end
               else if (scl_rise && (cnt_reg == BYTE_BITS))
                  mack_reg <= !sda_now;
               else if (scl_fall && (cnt_reg == BYTE_BITS))
               begin
                  if (mack_reg)
                  begin
                     tx_reg  <= mem[ptr_reg];
                     ptr_reg <= ptr_reg + 8'h01;
                     cnt_reg <= CNT_RESET;
                  end
                  else
                     state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // page commit into the array at the stop that ends a write
   always_ff @(posedge REF_CLK)
   begin
      if (!SYS_RST && stop_det && wrote_reg)
      begin
         for (int i = 0; i < PAGE_BYTES; i++)
         begin
            if (mask_reg[i])
               mem[{page_reg, 4'(i)}] <= pbuf[i];
         end
      end
   end

   // self-timed program cycle
   always_ff @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         busy_reg <= 1'b0;
         wcnt_reg <= '0;
      end
      else if (!busy_reg && stop_det && wrote_reg)
      begin
         busy_reg <= 1'b1;
         wcnt_reg <= '0;
      end
      else if (busy_reg)
      begin
         if (wcnt_reg == WCNT_W'(WRITE_CNT - 1))
            busy_reg <= 1'b0;
         wcnt_reg <= wcnt_reg + 1'b1;
      end
   end

   // open-drain drive and status
   always_ff @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         sda_oe_reg  <= 1'b0;
         standby_reg <= 1'b1;
      end
      else
      begin
         sda_oe_reg  <= ack_reg
                        || ((state_reg == ST_RDATA) && (cnt_reg < BYTE_BITS)
                            && !tx_reg[7]);
         standby_reg <= (state_reg == ST_IDLE) && !busy_reg;
      end
   end

   assign SDA_OUT    = 1'b0;
   assign SDA_OE     = sda_oe_reg;
   assign WRITE_BUSY = busy_reg;
   assign STANDBY    = standby_reg;

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);

   property p_start_resets;
      start_det |=> (state_reg == ST_SLAVE) && (cnt_reg == CNT_RESET);
   endproperty
   a_start_resets: assert property (p_start_resets)
      else $error("start did not restart the interface");
   property p_stop_idle;
      stop_det && !start_det |=> (state_reg == ST_IDLE) && !ack_reg;
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("stop did not return to idle");
   property p_idle_silent;
      (state_reg == ST_IDLE) && $past(state_reg == ST_IDLE) |-> !SDA_OE;
   endproperty
   a_idle_silent: assert property (p_idle_silent)
      else $error("sda driven while idle");
   property p_addr_ack;
      byte_done && (state_reg == ST_SLAVE) && !start_det && !stop_det
      && !busy_reg && (shift_reg[7:4] == DEV_TYPE)
      && (shift_reg[3:1] == sel_reg) |=> ack_reg ##1 SDA_OE;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("matching address not acknowledged");
   property p_type_mismatch;
      byte_done && (state_reg == ST_SLAVE) && !start_det && !stop_det
      && ((shift_reg[7:4] != DEV_TYPE) || (shift_reg[3:1] != sel_reg))
      |=> (state_reg == ST_IDLE) && !ack_reg;
   endproperty
   a_type_mismatch: assert property (p_type_mismatch)
      else $error("foreign address acknowledged");
   property p_busy_nack;
      byte_done && (state_reg == ST_SLAVE) && busy_reg
      |=> !ack_reg ##1 !SDA_OE;
   endproperty
   a_busy_nack: assert property (p_busy_nack)
      else $error("address acknowledged during write cycle");
   property p_stop_starts_write;
      stop_det && wrote_reg && !busy_reg |=> busy_reg ##1 !STANDBY;
   endproperty
   a_stop_starts_write: assert property (p_stop_starts_write)
      else $error("write cycle not started at stop");
   property p_write_length;
      $fell(busy_reg) |-> $past(wcnt_reg) == WCNT_W'(WRITE_CNT - 1);
   endproperty
   a_write_length: assert property (p_write_length)
      else $error("write cycle length wrong");
   property p_direction;
      ack_end && (state_reg == ST_SLAVE) && !start_det && !stop_det
      |=> (state_reg == (shift_reg[RW_BIT] ? ST_RDATA : ST_WORD));
   endproperty
   a_direction: assert property (p_direction)
      else $error("direction bit not honoured");
   property p_page_wrap;
      take_byte && (state_reg == ST_WDATA) && !start_det && !stop_det
      |=> (ptr_reg[7:4] == $past(ptr_reg[7:4]))
          && (ptr_reg[3:0] == $past(ptr_reg[3:0]) + 4'h1);
   endproperty
   a_page_wrap: assert property (p_page_wrap)
      else $error("write pointer left its page");
   c_byte_write: cover property (stop_det && wrote_reg && !busy_reg);
   c_read_byte: cover property (ack_end && (state_reg == ST_SLAVE)
                                && shift_reg[RW_BIT]);
   c_poll_nack: cover property (byte_done && (state_reg == ST_SLAVE)
                                && busy_reg);
   c_write_done: cover property ($fell(busy_reg));
endmodule
